// ===== pdsa_pkg.sv
package pdsa_pkg;
   // operation codes from the pipeline
   typedef enum logic [2:0] {
      PDSA_OP_IDLE,
      PDSA_OP_READ,
      PDSA_OP_WRITE,
      PDSA_OP_DUAL,
      PDSA_OP_TRD_LO,
      PDSA_OP_TRD_HI,
      PDSA_OP_TWR_LO,
      PDSA_OP_TWR_HI
   } pdsa_op_t;

   // instruction class, sets window stall cost
   typedef enum logic [1:0] {
      PDSA_CLS_OTHER,
      PDSA_CLS_MAC_PF,
      PDSA_CLS_MOVE,
      PDSA_CLS_MOVE_D
   } pdsa_cls_t;

   localparam int          PDSA_EA_W       = 16;
   localparam int          PDSA_PA_W       = 24;
   localparam int          PDSA_PAGE_W     = 8;
   localparam int          PDSA_WIN_LOW_W  = 15;
   localparam int          PDSA_EA_MSB     = 15;
   localparam int          PDSA_CFG_BIT    = 7;
   localparam logic [15:0] PDSA_ZERO_WORD  = 16'h0000;
   localparam logic [7:0]  PDSA_ZERO_BYTE  = 8'h00;
   // fixed x/y split, byte addresses, y inclusive
   localparam logic [15:0] PDSA_Y_BASE     = 16'h0C00;
   localparam logic [15:0] PDSA_Y_LAST     = 16'h0FFF;
   // implemented ram, above it reads zero unless the ea msb is set
   localparam logic [15:0] PDSA_RAM_LAST   = 16'h0FFF;
   localparam logic [1:0]  PDSA_STALL_ONE  = 2'h1;
   localparam logic [1:0]  PDSA_STALL_TWO  = 2'h2;
   localparam logic [1:0]  PDSA_STALL_NONE = 2'h0;
endpackage : pdsa_pkg

// ===== pdsa_space_check.sv
`timescale 1ns/1ns
// one read port: range check of an address against x or y space
module pdsa_space_check
   import pdsa_pkg::*;
(
   // address and port kind
   input  wire logic [15:0] addr,
   input  wire logic        dual,
   input  wire logic        y_port,
   // result
   output logic             valid
);
   logic in_y;
   logic in_ram;

   // fixed region decode, no software hook on purpose
   // hardwired boundary decode
   assign in_y   = (addr >= PDSA_Y_BASE) && (addr <= PDSA_Y_LAST);
   assign in_ram = (addr <= PDSA_RAM_LAST) || addr[PDSA_EA_MSB];

   always_comb begin
      if (!dual) begin
         valid = in_ram;
      end else if (y_port) begin
         valid = in_y;
      end else begin
         valid = in_ram && !in_y;
      end
   end
endmodule // pdsa_space_check

// ===== pdsa_core.sv
`timescale 1ns/1ns
// Behaviour
// - low word table read returns P15..0
// - low byte read selects P7..0 or P15..8
// - high word read gives P23..16, zero top
// - high byte read: P23..16 or zero
// - program address steps two per word
// - upper data half maps program page
// - window needs ea msb and enable
// - window address: page plus ea low 15
// - window returns low 16 program bits
// - window off during table access
// - outside repeat: one or two stall
// - in repeat: two at edges, else none
// - non-mac sees one unified x space
// - mac dual read x and y pointers
// - data writes on x write bus, table writes to flash
// - modulo both, bit-reverse x writes only
// - invalid accesses return zero
// - 16-bit byte-addressed effective addresses
// - x/y boundary fixed in hardware
// - table address is page and ea
module pdsa_core
   import pdsa_pkg::*;
#(
   parameter int MOD_W = 16
)(
   // clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  rst_n,
   // request from pipeline
   input  wire pdsa_op_t              op,
   input  wire pdsa_cls_t             op_class,
   input  wire logic                  byte_op,
   input  wire logic [PDSA_EA_W-1:0]  ea_x,
   input  wire logic [PDSA_EA_W-1:0]  ea_y,
   input  wire logic [15:0]           wr_data,
   input  wire logic                  wr_bit_rev,
   input  wire logic                  mod_x_en,
   input  wire logic                  mod_y_en,
   input  wire logic [MOD_W-1:0]      mod_x_start,
   input  wire logic [MOD_W-1:0]      mod_x_end,
   input  wire logic [MOD_W-1:0]      mod_y_start,
   input  wire logic [MOD_W-1:0]      mod_y_end,
   input  wire logic                  in_repeat,
   input  wire logic                  rpt_edge,
   // configuration
   input  wire logic                  program_window_enable,
   input  wire logic [PDSA_PAGE_W-1:0] window_page_register,
   input  wire logic [PDSA_PAGE_W-1:0] table_page_register,
   // memory read data
   input  wire logic [PDSA_PA_W-1:0]  prog_rdata,
   input  wire logic [15:0]           xram_rdata,
   input  wire logic [15:0]           yram_rdata,
   // memory addresses and strobes
   output logic [PDSA_PA_W-1:0]       prog_addr,
   output logic                       prog_rd,
   output logic                       prog_cfg,
   output logic [15:0]                x_addr,
   output logic                       x_rd,
   output logic                       x_wr,
   output logic [1:0]                 x_wr_be,
   output logic [15:0]                x_wdata,
   output logic [15:0]                y_addr,
   output logic                       y_rd,
   // flash programming hand-off
   output logic                       flash_wr_lo,
   output logic                       flash_wr_hi,
   output logic [PDSA_PA_W-1:0]       flash_addr,
   output logic [15:0]                flash_wdata,
   // results to pipeline
   output logic [15:0]                x_result,
   output logic [15:0]                y_result,
   output logic                       result_valid,
   output logic [1:0]                 stall_cycles
);
   // registered outputs
   logic [PDSA_PA_W-1:0] prog_addr_q, prog_addr_d;
   logic                 prog_rd_q, prog_rd_d, prog_cfg_q, prog_cfg_d;
   logic [15:0]          x_addr_q, x_addr_d, y_addr_q, y_addr_d;
   logic                 x_rd_q, x_rd_d, x_wr_q, x_wr_d, y_rd_q, y_rd_d;
   logic [1:0]           x_wr_be_q, x_wr_be_d;
   logic [15:0]          x_wdata_q, x_wdata_d;
   logic                 fl_lo_q, fl_lo_d, fl_hi_q, fl_hi_d;
   logic [PDSA_PA_W-1:0] fl_addr_q, fl_addr_d;
   logic [15:0]          fl_wdata_q, fl_wdata_d;
   logic [15:0]          x_res_q, x_res_d, y_res_q, y_res_d;
   logic                 res_v_q, res_v_d;
   logic [1:0]           stall_q, stall_d;
   // read-phase context, one cycle behind the request
   pdsa_op_t             rop_q, rop_d;
   logic                 rbyte_q, rbyte_d, rsel_q, rsel_d;
   logic                 rwin_q, rwin_d, rxv_q, rxv_d, ryv_q, ryv_d;

   logic       is_table;
   logic       is_dual;
   logic       win_hit;
   logic       x_ok;
   logic       y_ok;
   logic [15:0] ea_x_mod;
   logic [15:0] ea_y_mod;
   logic [15:0] ea_x_rev;

   // range checkers for both read ports
   pdsa_space_check u_chk_x (
      .addr   (ea_x_mod),
      .dual   (is_dual),
      .y_port (1'b0),
      .valid  (x_ok)
   );
   pdsa_space_check u_chk_y (
      .addr   (ea_y_mod),
      .dual   (is_dual),
      .y_port (1'b1),
      .valid  (y_ok)
   );

   // bit-reverse of the word index, low byte bit kept
   always_comb begin
      ea_x_rev = ea_x;
      for (int i = 1; i < PDSA_EA_W; i++) begin
         ea_x_rev[i] = ea_x[PDSA_EA_W - i];
      end
   end

   // modulo wrap past the buffer end, both spaces
   // modulo on x and y
   always_comb begin
      ea_x_mod = ea_x;
      ea_y_mod = ea_y;
      if (mod_x_en && (ea_x > 16'(mod_x_end))) begin
         ea_x_mod = 16'(mod_x_start);
      end
      if (mod_y_en && (ea_y > 16'(mod_y_end))) begin
         ea_y_mod = 16'(mod_y_start);
      end
   end

   assign is_table = (op == PDSA_OP_TRD_LO) || (op == PDSA_OP_TRD_HI) ||
                     (op == PDSA_OP_TWR_LO) || (op == PDSA_OP_TWR_HI);
   assign is_dual  = (op == PDSA_OP_DUAL);

   assign win_hit = ea_x_mod[PDSA_EA_MSB] && program_window_enable &&
                    !is_table &&
                    ((op == PDSA_OP_READ) || is_dual);

   // request phase: drive addresses and strobes
   always_comb begin
      prog_addr_d = '0;
      prog_rd_d   = 1'b0;
      prog_cfg_d  = 1'b0;
      x_addr_d    = ea_x_mod;
      y_addr_d    = ea_y_mod;
      x_rd_d      = 1'b0;
      x_wr_d      = 1'b0;
      x_wr_be_d   = 2'b00;
      x_wdata_d   = wr_data;
      y_rd_d      = 1'b0;
      fl_lo_d     = 1'b0;
      fl_hi_d     = 1'b0;
      fl_addr_d   = fl_addr_q;
      fl_wdata_d  = fl_wdata_q;
      stall_d     = PDSA_STALL_NONE;
      rop_d       = op;
      rbyte_d     = byte_op;
      rsel_d      = ea_x[0];
      rwin_d      = win_hit;
      rxv_d       = x_ok;
      ryv_d       = y_ok;
      if (is_table) begin
         // word step of two, lsb dropped
         prog_addr_d = {table_page_register, ea_x[15:1], 1'b0};
         prog_cfg_d  = table_page_register[PDSA_CFG_BIT];
         prog_rd_d   = (op == PDSA_OP_TRD_LO) || (op == PDSA_OP_TRD_HI);
         rxv_d       = 1'b1;
      end else if (win_hit) begin
         // page bits over ea low 15
         prog_addr_d = {1'b0, window_page_register,
                        ea_x_mod[PDSA_WIN_LOW_W-1:1], 1'b0};
         prog_rd_d   = 1'b1;
         rxv_d       = 1'b1;
         if (in_repeat) begin
            stall_d = rpt_edge ? PDSA_STALL_TWO : PDSA_STALL_NONE;
         end else if (op_class == PDSA_CLS_OTHER) begin
            stall_d = PDSA_STALL_TWO;
         end else begin
            stall_d = PDSA_STALL_ONE;
         end
      end else if (op == PDSA_OP_READ || is_dual) begin
         x_rd_d = x_ok;
      end
      if (is_dual) begin
         y_rd_d = y_ok;
      end
      if (op == PDSA_OP_WRITE) begin
         x_addr_d  = wr_bit_rev ? ea_x_rev : ea_x_mod;
         x_wr_d    = 1'b1;
         x_wr_be_d = byte_op ? (ea_x[0] ? 2'b10 : 2'b01) : 2'b11;
         x_wdata_d = byte_op ? {wr_data[7:0], wr_data[7:0]} : wr_data;
      end
      // pass table writes to flash logic
      if (op == PDSA_OP_TWR_LO || op == PDSA_OP_TWR_HI) begin
         fl_lo_d    = (op == PDSA_OP_TWR_LO);
         fl_hi_d    = (op == PDSA_OP_TWR_HI);
         fl_addr_d  = {table_page_register, ea_x[15:1], 1'b0};
         fl_wdata_d = wr_data;
      end
   end

   // read phase: steer returned data one cycle later
   always_comb begin
      x_res_d = PDSA_ZERO_WORD;
      y_res_d = PDSA_ZERO_WORD;
      res_v_d = 1'b0;
      unique case (rop_q)
         PDSA_OP_TRD_LO: begin
            res_v_d = 1'b1;
            if (!rbyte_q) begin
               x_res_d = prog_rdata[15:0];
            end else begin
               x_res_d = {PDSA_ZERO_BYTE,
                          rsel_q ? prog_rdata[15:8] : prog_rdata[7:0]};
            end
         end
         PDSA_OP_TRD_HI: begin
            res_v_d = 1'b1;
            if (!rbyte_q || !rsel_q) begin
               x_res_d = {PDSA_ZERO_BYTE, prog_rdata[23:16]};
            end else begin
               x_res_d = PDSA_ZERO_WORD;
            end
         end
         PDSA_OP_READ, PDSA_OP_DUAL: begin
            res_v_d = 1'b1;
            if (rwin_q) begin
               x_res_d = prog_rdata[15:0];
            end else if (rxv_q) begin
               x_res_d = xram_rdata;
            end
            if (rbyte_q && !(rop_q == PDSA_OP_DUAL)) begin
               x_res_d = {PDSA_ZERO_BYTE,
                          rsel_q ? x_res_d[15:8] : x_res_d[7:0]};
            end
            if (rop_q == PDSA_OP_DUAL && ryv_q) begin
               y_res_d = yram_rdata;
            end
         end
         PDSA_OP_IDLE, PDSA_OP_WRITE,
         PDSA_OP_TWR_LO, PDSA_OP_TWR_HI: begin
            res_v_d = 1'b0;
         end
      endcase
   end

   // all state registered, synchronous active-low reset
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         prog_addr_q <= '0;
         prog_rd_q   <= 1'b0;
         prog_cfg_q  <= 1'b0;
         x_addr_q    <= '0;
         y_addr_q    <= '0;
         x_rd_q      <= 1'b0;
         x_wr_q      <= 1'b0;
         x_wr_be_q   <= 2'b00;
         x_wdata_q   <= '0;
         y_rd_q      <= 1'b0;
         fl_lo_q     <= 1'b0;
         fl_hi_q     <= 1'b0;
         fl_addr_q   <= '0;
         fl_wdata_q  <= '0;
         x_res_q     <= '0;
         y_res_q     <= '0;
         res_v_q     <= 1'b0;
         stall_q     <= PDSA_STALL_NONE;
         rop_q       <= PDSA_OP_IDLE;
         rbyte_q     <= 1'b0;
         rsel_q      <= 1'b0;
         rwin_q      <= 1'b0;
         rxv_q       <= 1'b0;
         ryv_q       <= 1'b0;
      end else begin
         prog_addr_q <= prog_addr_d;
         prog_rd_q   <= prog_rd_d;
         prog_cfg_q  <= prog_cfg_d;
         x_addr_q    <= x_addr_d;
         y_addr_q    <= y_addr_d;
         x_rd_q      <= x_rd_d;
         x_wr_q      <= x_wr_d;
         x_wr_be_q   <= x_wr_be_d;
         x_wdata_q   <= x_wdata_d;
         y_rd_q      <= y_rd_d;
         fl_lo_q     <= fl_lo_d;
         fl_hi_q     <= fl_hi_d;
         fl_addr_q   <= fl_addr_d;
         fl_wdata_q  <= fl_wdata_d;
         x_res_q     <= x_res_d;
         y_res_q     <= y_res_d;
         res_v_q     <= res_v_d;
         stall_q     <= stall_d;
         rop_q       <= rop_d;
         rbyte_q     <= rbyte_d;
         rsel_q      <= rsel_d;
         rwin_q      <= rwin_d;
         rxv_q       <= rxv_d;
         ryv_q       <= ryv_d;
      end
   end

   assign prog_addr    = prog_addr_q;
   assign prog_rd      = prog_rd_q;
   assign prog_cfg     = prog_cfg_q;
   assign x_addr       = x_addr_q;
   assign x_rd         = x_rd_q;
   assign x_wr         = x_wr_q;
   assign x_wr_be      = x_wr_be_q;
   assign x_wdata      = x_wdata_q;
   assign y_addr       = y_addr_q;
   assign y_rd         = y_rd_q;
   assign flash_wr_lo  = fl_lo_q;
   assign flash_wr_hi  = fl_hi_q;
   assign flash_addr   = fl_addr_q;
   assign flash_wdata  = fl_wdata_q;
   assign x_result     = x_res_q;
   assign y_result     = y_res_q;
   assign result_valid = res_v_q;
   assign stall_cycles = stall_q;
endmodule // pdsa_core

// ===== pdsa_props.sv
`timescale 1ns/1ns
// port-level timing checks for the access core
module pdsa_props
   import pdsa_pkg::*;
(
   // clock, reset and request
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire pdsa_op_t    op,
   input wire pdsa_cls_t   op_class,
   input wire logic        byte_op,
   input wire logic [15:0] ea_x,
   input wire logic [15:0] wr_data,
   input wire logic        in_repeat,
   input wire logic        rpt_edge,
   input wire logic        program_window_enable,
   input wire logic [7:0]  window_page_register,
   input wire logic [7:0]  table_page_register,
   input wire logic [23:0] prog_rdata,
   // outputs watched
   input wire logic [23:0] prog_addr,
   input wire logic        prog_rd,
   input wire logic        x_wr,
   input wire logic        y_rd,
   input wire logic        flash_wr_lo,
   input wire logic [23:0] flash_addr,
   input wire logic [15:0] flash_wdata,
   input wire logic [15:0] x_result,
   input wire logic        result_valid,
   input wire logic [1:0]  stall_cycles
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // window read request, no stall from writes
   wire win_rd = op == PDSA_OP_READ && ea_x[15] && program_window_enable;
   // low word table read and its address step
   sequence trd_lo_s; op == PDSA_OP_TRD_LO && !byte_op; endsequence
   sequence lo_addr_s;
      prog_rd && prog_addr == {$past(table_page_register),
                               $past(ea_x[15:1]), 1'b0};
   endsequence
   tbl_addr_a: assert property (trd_lo_s |=> lo_addr_s)
      else $error("table address wrong");
   lo_word_a: assert property (trd_lo_s ##1 lo_addr_s |=>
      result_valid && x_result == $past(prog_rdata[15:0]))
      else $error("low table word wrong");
   hi_word_a: assert property (op == PDSA_OP_TRD_HI && !byte_op
      |=> ##1 result_valid && x_result == {8'h00, $past(prog_rdata[23:16])})
      else $error("high table word wrong");
   win_addr_a: assert property (win_rd |=> prog_rd && prog_addr ==
      {1'b0, $past(window_page_register), $past(ea_x[14:1]), 1'b0})
      else $error("window address wrong");
   win_off_a: assert property (op == PDSA_OP_READ &&
      !program_window_enable |=> !prog_rd)
      else $error("window used while disabled");
   stall_cost_a: assert property (win_rd && !in_repeat |=>
      stall_cycles == (($past(op_class) == PDSA_CLS_OTHER) ? 2'h2 : 2'h1))
      else $error("window stall wrong");
   rpt_stall_a: assert property (win_rd && in_repeat |=>
      stall_cycles == ($past(rpt_edge) ? 2'h2 : 2'h0))
      else $error("repeat stall wrong");
   x_write_a: assert property (op == PDSA_OP_WRITE |=>
      x_wr && !y_rd)
      else $error("write not on x bus");
   flash_fwd_a: assert property (op == PDSA_OP_TWR_LO |=>
      flash_wr_lo && flash_wdata == $past(wr_data) && flash_addr ==
      {$past(table_page_register), $past(ea_x[15:1]), 1'b0})
      else $error("table write not forwarded");
endmodule // pdsa_props
bind pdsa_core pdsa_props pdsa_props_i (.core_clk, .rst_n, .op, .op_class,
   .byte_op, .ea_x, .wr_data, .in_repeat, .rpt_edge, .program_window_enable,
   .window_page_register, .table_page_register, .prog_rdata, .prog_addr,
   .prog_rd, .x_wr, .y_rd, .flash_wr_lo, .flash_addr, .flash_wdata,
   .x_result, .result_valid, .stall_cycles);

// ===== pdsa_mem_model.sv
`timescale 1ns/1ns
// memory contents computed from the address, read combinationally off the registered addresses
module pdsa_mem_model (
   // addresses and strobes
   input  wire logic [23:0] prog_addr,
   input  wire logic        prog_rd,
   input  wire logic [15:0] x_addr,
   input  wire logic        x_rd,
   input  wire logic [15:0] y_addr,
   input  wire logic        y_rd,
   // read data
   output logic [23:0]      prog_rdata,
   output logic [15:0]      xram_rdata,
   output logic [15:0]      yram_rdata
);
   logic [23:0] pw;
   // idle buses show the inverse so stale reads cannot match
   always_comb begin
      pw = {prog_addr[7:0] ^ 8'hA5,
            prog_addr[15:0] ^ {prog_addr[23:16], 8'h3C}};
      prog_rdata = prog_rd ? pw : ~pw;
      xram_rdata = x_rd ? x_addr ^ 16'h0F0F : ~(x_addr ^ 16'h0F0F);
      yram_rdata = y_rd ? y_addr ^ 16'hF0F0 : ~(y_addr ^ 16'hF0F0);
   end
endmodule // pdsa_mem_model

// ===== program_data_space_access_tb.sv
`timescale 1ns/1ns
module program_data_space_access_tb
   import pdsa_pkg::*;
;
   typedef struct {pdsa_op_t op; logic b, en; logic [15:0] ea, ey, xe, ye;}
      pdsa_row_t;
   logic core_clk = 1'b0, rst_n = 1'b0, byte_op = 1'b0, wr_bit_rev = 1'b0;
   logic mod_x_en = 1'b0, mod_y_en = 1'b0, in_repeat = 1'b0, rpt_edge = 1'b0;
   logic program_window_enable = 1'b0;
   pdsa_op_t op = PDSA_OP_IDLE;
   pdsa_cls_t op_class = PDSA_CLS_OTHER;
   logic [15:0] ea_x = 16'h0000, ea_y = 16'h0000, wr_data = 16'h0000;
   logic [15:0] mod_x_start = 16'h0100, mod_x_end = 16'h0110;
   logic [15:0] mod_y_start = 16'h0C00, mod_y_end = 16'h0C10;
   logic [7:0]  window_page_register = 8'h03, table_page_register = 8'h92;
   logic [23:0] prog_rdata, prog_addr, flash_addr;
   logic [15:0] xram_rdata, yram_rdata, x_addr, x_wdata, y_addr, flash_wdata;
   logic [15:0] x_result, y_result;
   logic        prog_rd, prog_cfg, x_rd, x_wr, y_rd, flash_wr_lo, flash_wr_hi;
   logic        result_valid;
   logic [1:0]  x_wr_be, stall_cycles;
   int          fail_count = 0, n_tests = 0;
   pdsa_row_t   rows [14];

   pdsa_core pdsa_core_i (.core_clk, .rst_n, .op, .op_class, .byte_op, .ea_x,
      .ea_y, .wr_data, .wr_bit_rev, .mod_x_en, .mod_y_en, .mod_x_start,
      .mod_x_end, .mod_y_start, .mod_y_end, .in_repeat, .rpt_edge,
      .program_window_enable, .window_page_register, .table_page_register,
      .prog_rdata, .xram_rdata, .yram_rdata, .prog_addr, .prog_rd, .prog_cfg,
      .x_addr, .x_rd, .x_wr, .x_wr_be, .x_wdata, .y_addr, .y_rd, .flash_wr_lo,
      .flash_wr_hi, .flash_addr, .flash_wdata, .x_result, .y_result,
      .result_valid, .stall_cycles);
   pdsa_mem_model pdsa_mem_model_i (.prog_addr, .prog_rd, .x_addr, .x_rd,
      .y_addr, .y_rd, .prog_rdata, .xram_rdata, .yram_rdata);

   // 125 MHz core clock
   always #4 core_clk = ~core_clk;

   // expected program word contents
   function automatic logic [23:0] pw(logic [23:0] a);
      return {a[7:0] ^ 8'hA5, a[15:0] ^ {a[23:16], 8'h3C}};
   endfunction
   function automatic logic [15:0] tr(logic hi, logic b, logic [15:0] a);
      logic [23:0] p;
      p = pw({table_page_register, a[15:1], 1'b0});
      if (hi) return (b && a[0]) ? 16'h0000 : {8'h00, p[23:16]};
      if (b) return {8'h00, a[0] ? p[15:8] : p[7:0]};
      return p[15:0];
   endfunction
   function automatic logic [15:0] wv(logic [15:0] a);
      logic [23:0] p;
      p = pw({1'b0, window_page_register, a[14:1], 1'b0});
      return p[15:0];
   endfunction

   // wide enough that strobe bits packed above an address are kept
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // one request cycle, returns just after the edge that launches strobes
   task automatic send(pdsa_op_t o, logic b, logic [15:0] ex, logic [15:0] ey,
                       logic en, pdsa_cls_t c, logic [1:0] r);
      @(posedge core_clk);
      op <= o;
      byte_op <= b;
      ea_x <= ex;
      ea_y <= ey;
      program_window_enable <= en;
      op_class <= c;
      {in_repeat, rpt_edge} <= r;
      @(posedge core_clk);
      op <= PDSA_OP_IDLE;
      #1;
   endtask
   // bounded wait for the result pulse
   task automatic get_res();
      for (int k = 0; k < 4 && result_valid !== 1'b1; k++) begin
         @(posedge core_clk);
         #1;
      end
      if (result_valid !== 1'b1) begin
         fail_count++;
         conclude();
      end
   endtask

   initial begin
      repeat (9) @(posedge core_clk);
      #1;
      check("reset outputs", {prog_rd, x_wr, y_rd, result_valid}, 0);
      @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      rows[0] = '{PDSA_OP_TRD_LO, 0, 0, 16'h1234, 0, tr(0, 0, 16'h1234), 0};
      rows[1] = '{PDSA_OP_TRD_LO, 1, 0, 16'h1234, 0, tr(0, 1, 16'h1234), 0};
      rows[2] = '{PDSA_OP_TRD_LO, 1, 0, 16'h1235, 0, tr(0, 1, 16'h1235), 0};
      rows[3] = '{PDSA_OP_TRD_HI, 0, 0, 16'h1234, 0, tr(1, 0, 16'h1234), 0};
      rows[4] = '{PDSA_OP_TRD_HI, 1, 0, 16'h1234, 0, tr(1, 1, 16'h1234), 0};
      rows[5] = '{PDSA_OP_TRD_HI, 1, 0, 16'h1235, 0, 16'h0000, 0};
      rows[6] = '{PDSA_OP_TRD_LO, 0, 1, 16'h8004, 0, tr(0, 0, 16'h8004), 0};
      rows[7] = '{PDSA_OP_READ, 0, 1, 16'h8002, 0, wv(16'h8002), 0};
      rows[8] = '{PDSA_OP_READ, 0, 0, 16'h8002, 0, 16'h8F0D, 0};
      rows[9] = '{PDSA_OP_READ, 0, 0, 16'h0100, 0, 16'h0E0F, 0};
      rows[10] = '{PDSA_OP_READ, 0, 0, 16'h0C10, 0, 16'h031F, 0};
      rows[11] = '{PDSA_OP_READ, 0, 0, 16'h2000, 0, 16'h0000, 0};
      rows[12] = '{PDSA_OP_DUAL, 0, 0, 16'h0100, 16'h0C00, 16'h0E0F, 16'hFCF0};
      rows[13] = '{PDSA_OP_DUAL, 0, 0, 16'h0C00, 16'h0100, 0, 0};
      // table, window and x/y read data
      foreach (rows[i]) begin
         send(rows[i].op, rows[i].b, rows[i].ea, rows[i].ey, rows[i].en,
              PDSA_CLS_OTHER, 2'b00);
         get_res();
         check("x_result", x_result, rows[i].xe);
         if (rows[i].op == PDSA_OP_DUAL)
            check("y_result", y_result, rows[i].ye);
      end
      // window stall by class, then inside repeat
      for (int c = 0; c < 4; c++) begin
         send(PDSA_OP_READ, 0, 16'h8002, 0, 1, pdsa_cls_t'(c), 2'b00);
         check("stall", stall_cycles, (c == 0) ? PDSA_STALL_TWO
               : PDSA_STALL_ONE);
      end
      send(PDSA_OP_READ, 0, 16'h8002, 0, 1, PDSA_CLS_MOVE, 2'b10);
      check("stall rpt", stall_cycles, PDSA_STALL_NONE);
      send(PDSA_OP_READ, 0, 16'h8002, 0, 1, PDSA_CLS_MOVE, 2'b11);
      check("stall rpt edge", stall_cycles, PDSA_STALL_TWO);
      // configuration space select on a table read
      send(PDSA_OP_TRD_HI, 0, 16'h1234, 0, 0, PDSA_CLS_OTHER, 2'b00);
      check("prog_addr", prog_addr, 24'h921234);
      check("prog_cfg", prog_cfg, 1'b1);
      // table write hand-off, user page
      @(posedge core_clk);
      table_page_register <= 8'h12;
      wr_data <= 16'h00C3;
      send(PDSA_OP_TWR_HI, 0, 16'h4466, 0, 0, PDSA_CLS_OTHER, 2'b00);
      check("flash hi", {flash_wr_hi, flash_addr}, 25'h1124466);
      check("flash data", flash_wdata, 16'h00C3);
      send(PDSA_OP_TWR_LO, 0, 16'h0010, 0, 0, PDSA_CLS_OTHER, 2'b00);
      check("flash lo", {flash_wr_lo, flash_wr_hi, flash_addr},
            26'h2120010);
      // bit-reversed x write stays off the y bus
      @(posedge core_clk);
      wr_bit_rev <= 1'b1;
      wr_data <= 16'hBEEF;
      send(PDSA_OP_WRITE, 0, 16'h0002, 0, 0, PDSA_CLS_OTHER, 2'b00);
      check("x write", {x_wr, y_rd, x_wr_be, x_addr}, 20'hB8000);
      check("x_wdata", x_wdata, 16'hBEEF);
      // modulo wrap on both read ports
      @(posedge core_clk);
      wr_bit_rev <= 1'b0;
      mod_x_en <= 1'b1;
      mod_y_en <= 1'b1;
      send(PDSA_OP_DUAL, 0, 16'h0112, 16'h0C12, 0, PDSA_CLS_OTHER, 2'b00);
      check("x_addr wrap", x_addr, 16'h0100);
      check("y_addr wrap", y_addr, 16'h0C00);
      check("dual strobes", {x_rd, y_rd}, 2'b11);
      conclude();
   end
endmodule // program_data_space_access_tb
